// *** host_bus_pkg.sv ***
// Shared constants, types and decode functions for the display host bus front end
`default_nettype none
package host_bus_pkg;

  // Host bus mode codes, four bits: two command bits above two strap pins
  localparam logic [3:0] MODE_SER4    = 4'h0;
  localparam logic [3:0] MODE_SER3    = 4'h1;
  localparam logic [3:0] MODE_M68_8   = 4'h3;
  localparam logic [3:0] MODE_I80_8   = 4'h2;
  localparam logic [3:0] MODE_M68_16  = 4'h7;
  localparam logic [3:0] MODE_I80_16  = 4'h6;
  localparam logic [3:0] MODE_M68_18  = 4'hF;
  localparam logic [3:0] MODE_I80_18  = 4'hE;
  localparam logic [1:0] MODE_HI_RST  = 2'h0;
  localparam logic [7:0] CMD_MODE_HI  = 8'h36;

  // Bus widths and serial word lengths
  localparam int         DATA_W       = 18;
  localparam logic [3:0] SER4_BITS    = 4'h8;
  localparam logic [3:0] SER3_BITS    = 4'h9;
  localparam logic [17:0] MASK_8      = 18'h000FF;
  localparam logic [17:0] MASK_16     = 18'h0FFFF;
  localparam logic [17:0] MASK_18     = 18'h3FFFF;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_STATUS  = 12'h004;
  localparam logic [11:0] REG_RXWORD  = 12'h008;
  localparam logic [11:0] REG_TXDATA  = 12'h00C;
  localparam logic [11:0] REG_FRAME   = 12'h010;

  // Field positions
  localparam int CTRL_DISP_BIT  = 2;
  localparam int RX_DC_BIT      = 18;
  localparam int RX_VALID_BIT   = 31;
  localparam int ST_VALID_BIT   = 4;
  localparam int ST_OSC_BIT     = 5;
  localparam int ST_SYNC_BIT    = 6;
  localparam int ST_INIT_BIT    = 7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Reset values
  localparam logic [17:0] TXDATA_RST  = 18'h00000;
  localparam logic [15:0] FRAME_RST   = 16'h00A0;

  // Timing: internal oscillator tick and frame sync width
  localparam int CLK_PERIOD_NS  = 8;
  localparam int OSC_TICK_NS    = 40;
  localparam int OSC_TICK_CYC   = (OSC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] SYNC_TICKS = 16'h0004;

  typedef enum {KIND_SER4, KIND_SER3, KIND_M68, KIND_I80, KIND_BAD} bus_kind_t;

  // Mode code to bus style
  function automatic bus_kind_t mode_kind(input logic [3:0] m);
    bus_kind_t k;
    k = KIND_BAD;
    if (m == MODE_SER4) k = KIND_SER4;
    else if (m == MODE_SER3) k = KIND_SER3;
    else if (m == MODE_M68_8 || m == MODE_M68_16 || m == MODE_M68_18) k = KIND_M68;
    else if (m == MODE_I80_8 || m == MODE_I80_16 || m == MODE_I80_18) k = KIND_I80;
    return k;
  endfunction

  // Mode code to active data lines
  function automatic logic [17:0] mode_mask(input logic [3:0] m);
    logic [17:0] r;
    r = MASK_8;
    if (m[3]) r = MASK_18;
    else if (m[2]) r = MASK_16;
    return r;
  endfunction

endpackage
`default_nettype wire

// *** pin_sync.sv ***
// Two-flop synchroniser bank with a third stage for edge detection
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_prev
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  generate
    if (W < 1)
    begin : g_bad
      $error("pin_sync width must be at least one");
    end
  endgenerate

  // Stage one feeds only stage two; edges look at stages two and three
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
      prev_r <= RST_VAL;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_prev  = prev_r;

endmodule // pin_sync
`default_nettype wire

// *** display_host_bus_select.sv ***
// Display controller host bus front end: mode select, bus decode, frame sync
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module display_host_bus_select
  import host_bus_pkg::*;
#(
  parameter int OSC_DIV = host_bus_pkg::OSC_TICK_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Host pins
  input  wire logic [1:0]  i_host_bus_mode,
  input  wire logic        i_cs_n,
  input  wire logic        i_dc,
  input  wire logic        i_rw_wr,
  input  wire logic        i_e_rd,
  input  wire logic [17:0] i_data,
  output logic      [17:0] o_data,
  output logic             o_data_oe,
  input  wire logic        i_hard_init_n,
  input  wire logic        i_osc_source_select,
  input  wire logic        i_ext_clk,
  output logic             o_frame_sync_out,
  output logic             o_seg_drive_en,
  // Received word stream
  output logic             o_word_valid,
  output logic      [17:0] o_word_data,
  output logic             o_word_is_data,
  output logic      [3:0]  o_host_bus_mode
);

  generate
    if (OSC_DIV < 2 || OSC_DIV > 65535)
    begin : g_bad_div
      $error("OSC_DIV must lie in 2..65535");
    end
  endgenerate

  // Synchronised host pins; selects and write strobe idle high, E low, straps 00
  // E resets low so a 6800 host parked with E low sees no false fall after reset
  localparam logic [8:0] CTL_RST = 9'h1CC;
  logic [8:0]  ctl_s;
  logic [8:0]  ctl_p;
  logic [17:0] data_s;

  pin_sync #(.W(9), .RST_VAL(CTL_RST)) u_ctl_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_cs_n, i_dc, i_rw_wr, i_e_rd, i_ext_clk, i_hard_init_n,
               i_osc_source_select, i_host_bus_mode}),
    .o_level (ctl_s),
    .o_prev  (ctl_p)
  );

  pin_sync #(.W(18), .RST_VAL(18'h00000)) u_data_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_data),
    .o_level (data_s),
    .o_prev  ()
  );

  // Register state
  logic [1:0]  mode_hi_r;
  logic        disp_on_r;
  logic [17:0] tx_r;
  logic [15:0] frame_div_r;
  logic [17:0] rx_data_r;
  logic        rx_dc_r;
  logic        rx_valid_r;
  logic        arm_r;
  logic [8:0]  sr_r;
  logic [3:0]  bit_cnt_r;
  logic        oe_r;
  logic [17:0] dout_r;
  logic [15:0] osc_cnt_r;
  logic [15:0] frm_cnt_r;
  logic        sync_r;
  logic        wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic        word_v_r;
  logic [17:0] word_d_r;
  logic        word_dc_r;

  // Pin decode
  wire         cs_n_s   = ctl_s[8];
  wire         dc_s     = ctl_s[7];
  wire         rw_s     = ctl_s[6];
  wire         rw_p     = ctl_p[6];
  wire         e_s      = ctl_s[5];
  wire         e_p      = ctl_p[5];
  wire         ext_s    = ctl_s[4];
  wire         ext_p    = ctl_p[4];
  wire         init     = ~ctl_s[3];
  wire         osc_int  = ctl_s[2];
  wire  [3:0]  mode     = {mode_hi_r, ctl_s[1:0]};
  wire  [17:0] mask     = mode_mask(mode);
  bus_kind_t   kind;
  assign kind = mode_kind(mode);
  wire         sel      = ~cs_n_s;
  wire         rw_rise  = rw_s & ~rw_p;
  wire         e_rise   = e_s & ~e_p;
  wire         e_fall   = ~e_s & e_p;
  wire         is_ser   = (kind == KIND_SER4) || (kind == KIND_SER3);

  // Parallel strobes per style
  wire m68_wr   = (kind == KIND_M68) & sel & e_fall & ~rw_s;
  wire m68_rd   = (kind == KIND_M68) & sel & e_rise & rw_s;
  wire m68_end  = (kind == KIND_M68) & e_fall;
  wire i80_wr   = (kind == KIND_I80) & sel & rw_rise;
  wire i80_rd   = (kind == KIND_I80) & sel & ~e_s & ~oe_r;
  wire i80_end  = (kind == KIND_I80) & e_s;

  // Serial: direction pin is the shift clock, line 0 the data
  wire  [3:0] ser_len  = (kind == KIND_SER3) ? SER3_BITS : SER4_BITS;
  wire        sclk_up  = is_ser & sel & rw_rise;
  wire        ser_last = sclk_up & (bit_cnt_r == ser_len - 4'h1);
  wire  [8:0] sr_nxt   = {sr_r[7:0], data_s[0]};
  wire        ser_dc   = (kind == KIND_SER3) ? sr_r[7] : dc_s;

  // Committed word from whichever style is active
  wire        word_fire = ser_last | m68_wr | i80_wr;
  wire [17:0] word_nxt  = ser_last ? {10'h000, sr_nxt[7:0]} : (data_s & mask);
  wire        dc_nxt    = ser_last ? ser_dc : dc_s;

  // Bus side decode
  wire        ahb_acc   = i_hsel & i_htrans[1] & i_hready;
  wire [11:0] a_addr    = i_haddr[11:0];
  wire        rd_rx     = ahb_acc & ~i_hwrite & (a_addr == REG_RXWORD);
  wire        wr_ok     = wr_pend_r;
  wire        wr_ctrl   = wr_ok & (wr_addr_r == REG_CTRL);
  wire        wr_tx     = wr_ok & (wr_addr_r == REG_TXDATA);
  wire        wr_frame  = wr_ok & (wr_addr_r == REG_FRAME);
  wire        host_36   = word_fire & ~dc_nxt & (word_nxt[7:0] == CMD_MODE_HI);
  wire        host_par  = word_fire & dc_nxt & arm_r;

  // Selected frame clock source
  wire        osc_tick  = (osc_cnt_r == 16'(OSC_DIV - 1));
  wire        src_tick  = osc_int ? osc_tick : (ext_s & ~ext_p);
  wire        frm_wrap  = (frm_cnt_r >= frame_div_r - 16'h0001);

  logic [31:0] rd_mux;

  // Read mux, registered at the address phase
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (a_addr == REG_CTRL)
      rd_mux = {29'h0, disp_on_r, mode_hi_r};
    else if (a_addr == REG_STATUS)
      rd_mux = {24'h0, init, sync_r, osc_int, kind != KIND_BAD, mode};
    else if (a_addr == REG_RXWORD)
      rd_mux = {rx_valid_r, 12'h000, rx_dc_r, rx_data_r};
    else if (a_addr == REG_TXDATA)
      rd_mux = {14'h0000, tx_r};
    else if (a_addr == REG_FRAME)
      rd_mux = {16'h0000, frame_div_r};
  end

  // Bus slave pipeline: zero wait states, word writes only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata_r  <= 32'h00000000;
    end
    else
    begin
      wr_pend_r <= ahb_acc & i_hwrite & (i_hsize == HSIZE_WORD);
      if (ahb_acc)
        wr_addr_r <= a_addr;
      if (ahb_acc & ~i_hwrite)
        hrdata_r <= rd_mux;
    end
  end

  // Control registers; mode bits also set by host command then parameter
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_hi_r   <= MODE_HI_RST;
      disp_on_r   <= 1'b0;
      tx_r        <= TXDATA_RST;
      frame_div_r <= FRAME_RST;
      arm_r       <= 1'b0;
    end
    else if (init)
    begin
      mode_hi_r   <= MODE_HI_RST;
      disp_on_r   <= 1'b0;
      tx_r        <= TXDATA_RST;
      frame_div_r <= FRAME_RST;
      arm_r       <= 1'b0;
    end
    else
    begin
      if (host_par)
        mode_hi_r <= word_nxt[1:0];
      else if (wr_ctrl)
        mode_hi_r <= i_hwdata[1:0];
      if (wr_ctrl)
        disp_on_r <= i_hwdata[CTRL_DISP_BIT];
      if (wr_tx)
        tx_r <= i_hwdata[17:0];
      if (wr_frame)
        frame_div_r <= (i_hwdata[15:0] == 16'h0000) ? 16'h0001 : i_hwdata[15:0];
      if (word_fire)
        arm_r <= host_36;
    end
  end

  // Received word holding register; a new word beats a clearing read
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_data_r  <= 18'h00000;
      rx_dc_r    <= 1'b0;
      rx_valid_r <= 1'b0;
    end
    else if (init)
      rx_valid_r <= 1'b0;
    else if (word_fire)
    begin
      rx_data_r  <= word_nxt;
      rx_dc_r    <= dc_nxt;
      rx_valid_r <= 1'b1;
    end
    else if (rd_rx)
      rx_valid_r <= 1'b0;
  end

  // Serial shifter; deselect restarts the word so a glitch cannot skew framing
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sr_r      <= 9'h000;
      bit_cnt_r <= 4'h0;
    end
    else if (init || !sel || !is_ser)
      bit_cnt_r <= 4'h0;
    else if (sclk_up)
    begin
      sr_r      <= sr_nxt;
      bit_cnt_r <= ser_last ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  // Parallel read drive: on from strobe start to strobe end or deselect
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      oe_r   <= 1'b0;
      dout_r <= 18'h00000;
    end
    else if (init || !sel || m68_end || i80_end || is_ser)
      oe_r <= 1'b0;
    else if (m68_rd || i80_rd)
    begin
      oe_r   <= 1'b1;
      dout_r <= tx_r & mask;
    end
  end

  // Word stream output, one-cycle strobe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      word_v_r  <= 1'b0;
      word_d_r  <= 18'h00000;
      word_dc_r <= 1'b0;
    end
    else
    begin
      word_v_r <= word_fire & ~init;
      if (word_fire)
      begin
        word_d_r  <= word_nxt;
        word_dc_r <= dc_nxt;
      end
    end
  end

  // Frame timing from the selected source; external clock ignored on internal
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      osc_cnt_r <= 16'h0000;
      frm_cnt_r <= 16'h0000;
      sync_r    <= 1'b0;
    end
    else if (init)
    begin
      osc_cnt_r <= 16'h0000;
      frm_cnt_r <= 16'h0000;
      sync_r    <= 1'b0;
    end
    else
    begin
      osc_cnt_r <= osc_tick ? 16'h0000 : osc_cnt_r + 16'h0001;
      if (src_tick)
      begin
        frm_cnt_r <= frm_wrap ? 16'h0000 : frm_cnt_r + 16'h0001;
        sync_r    <= frm_wrap | (frm_cnt_r + 16'h0001 < SYNC_TICKS);
      end
    end
  end

  // Outputs
  assign o_hrdata         = hrdata_r;
  assign o_hreadyout      = 1'b1;
  assign o_hresp          = 1'b0;
  assign o_data           = dout_r;
  assign o_data_oe        = oe_r;
  assign o_frame_sync_out = sync_r;
  assign o_seg_drive_en   = disp_on_r;
  assign o_word_valid     = word_v_r;
  assign o_word_data      = word_d_r;
  assign o_word_is_data   = word_dc_r;
  assign o_host_bus_mode  = mode;

endmodule // display_host_bus_select
`default_nettype wire

// *** host_bus_asserts.sv ***
// Port-level checker for the display host bus front end
`timescale 1ns/100ps
`default_nettype none
module host_bus_asserts (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_hard_init_n,
  input  wire logic [17:0] o_data,
  input  wire logic        o_data_oe,
  input  wire logic        o_seg_drive_en,
  input  wire logic        o_word_valid,
  input  wire logic [3:0]  o_host_bus_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Held long enough to clear the synchroniser and one register stage
  sequence init_held;
    !i_hard_init_n [*6];
  endsequence
  sequence cs_idle;
    i_cs_n [*6];
  endsequence

  // Mode, select gating, pulse shape and width masking
  chk_mode_reset: assert property ($rose(i_rst_n) |-> o_host_bus_mode[3:2] == 2'h0)
    else $error("mode high bits not cleared by reset");
  chk_init_mode: assert property (init_held |-> o_host_bus_mode[3:2] == 2'h0)
    else $error("mode high bits kept through hard init");
  chk_mode_legal: assert property (o_word_valid |-> $past(o_host_bus_mode) inside
    {4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hE, 4'hF})
    else $error("word taken under an undefined mode");
  chk_cs_gate: assert property (o_word_valid |-> !$past(i_cs_n, 4))
    else $error("word taken while not selected");
  chk_cs_release: assert property (cs_idle |-> !o_data_oe)
    else $error("bus driven while deselected");
  chk_init_seg: assert property (init_held |-> !o_seg_drive_en)
    else $error("segments driven during hard init");
  chk_serial_noread: assert property (o_host_bus_mode[3:1] == 3'h0 |-> !o_data_oe)
    else $error("bus driven in a serial mode");
  chk_width_mask: assert property (o_data_oe && !o_host_bus_mode[3] |-> o_data[17:16] == 2'h0)
    else $error("read data wider than the mode");
  chk_word_pulse: assert property (o_word_valid |=> !o_word_valid)
    else $error("word pulse longer than one cycle");
endmodule // host_bus_asserts

bind display_host_bus_select host_bus_asserts u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_hard_init_n(i_hard_init_n),
  .o_data(o_data), .o_data_oe(o_data_oe), .o_seg_drive_en(o_seg_drive_en),
  .o_word_valid(o_word_valid), .o_host_bus_mode(o_host_bus_mode)
);
`default_nettype wire

// *** host_mcu_model.sv ***
// Host microcontroller model on the far side of the display host pins
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model (
  input  wire logic        i_clk,
  input  wire logic [17:0] i_bus,
  output logic             o_cs_n,
  output logic             o_dc,
  output logic             o_rw_wr,
  output logic             o_e_rd,
  output logic [17:0]      o_data
);
  // Deselected, strobes idle, serial clock parked
  initial
  begin
    o_cs_n  = 1'b1;
    o_dc    = 1'b0;
    o_rw_wr = 1'b1;
    o_e_rd  = 1'b0;
    o_data  = 18'h00000;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Kind 0 8080, 1 6800, 2 4-wire, 3 3-wire; nb serial bits before release
  task automatic write_word(input int k, input logic sel_n, input logic dc,
                            input logic [17:0] d, input int nb);
    logic [8:0] sh;
    sh = {dc, d[7:0]};
    o_rw_wr <= (k == 0);
    o_e_rd  <= (k == 0); // tied low in serial modes
    o_dc    <= (k == 3) ? 1'b0 : dc;
    o_data  <= (k >= 2) ? 18'h00000 : d;
    wait_n(3);
    o_cs_n  <= sel_n;
    wait_n(3);
    if (k < 2)
    begin
      if (k == 0) o_rw_wr <= 1'b0;
      else o_e_rd <= 1'b1;
      wait_n(3);
      if (k == 0) o_rw_wr <= 1'b1;
      else o_e_rd <= 1'b0;
      wait_n(3);
    end
    else
      for (int i = 0; i < nb; i++)
      begin
        o_data[0] <= sh[(k == 3) ? 8 - i : 7 - i];
        o_data[1] <= ~o_data[1]; // left open, so it wanders
        wait_n(4);
        o_rw_wr   <= 1'b1;
        wait_n(4);
        o_rw_wr   <= 1'b0;
      end
    wait_n(3);
    o_cs_n  <= 1'b1;
    o_data  <= ~o_data;
  endtask

  // Parallel read: the bus is taken before the strobe is let go
  task automatic read_word(input int k, output logic [17:0] v);
    o_rw_wr <= 1'b1;
    o_e_rd  <= (k == 0);
    o_dc    <= 1'b1;
    o_data  <= 18'h15555;
    wait_n(3);
    o_cs_n  <= 1'b0;
    wait_n(3);
    o_e_rd  <= (k == 1);
    wait_n(8);
    v = i_bus;
    o_e_rd  <= (k == 0);
    wait_n(4);
    o_cs_n  <= 1'b1;
  endtask
endmodule // host_mcu_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the display host bus front end
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import host_bus_pkg::*;
  typedef struct packed {logic [3:0] m; logic dc; logic [17:0] d; logic [17:0] e;} row_t;
  localparam int DIV = 2;
  localparam int FRM = 8;
  logic        clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, init_n = 1'b1;
  logic        osc_sel = 1'b1, ext_clk = 1'b0, hready, hresp, last_dc;
  logic        cs_n, dc, rw_wr, e_rd, oe, fsync, seg_en, wv, wd_dc;
  logic [1:0]  htrans = 2'h0, strap = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  mode;
  logic [17:0] hdata, ddata, bus, wdata, last_w, v;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  int          n_mismatch = 0, total_checks = 0, n_words = 0, w0, c;
  row_t rows [8] = '{'{4'h2, 1'b0, 18'h3FF5A, 18'h0005A}, '{4'h3, 1'b1, 18'h000A5, 18'h000A5},
    '{4'h6, 1'b1, 18'h1BEEF, 18'h0BEEF}, '{4'h7, 1'b0, 18'h01234, 18'h01234},
    '{4'hE, 1'b1, 18'h2ABCD, 18'h2ABCD}, '{4'hF, 1'b1, 18'h35555, 18'h35555},
    '{4'h0, 1'b1, 18'h000C3, 18'h000C3}, '{4'h1, 1'b0, 18'h0003C, 18'h0003C}};

  // Clock, and an external source of 64 ns out of phase with it
  always #4 clk = ~clk;
  always #32 if (!osc_sel) ext_clk = ~ext_clk;
  assign bus = oe ? ddata : hdata;

  display_host_bus_select #(.OSC_DIV(DIV)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_host_bus_mode(strap),
    .i_cs_n(cs_n), .i_dc(dc), .i_rw_wr(rw_wr), .i_e_rd(e_rd), .i_data(bus),
    .o_data(ddata), .o_data_oe(oe), .i_hard_init_n(init_n), .i_osc_source_select(osc_sel),
    .i_ext_clk(ext_clk), .o_frame_sync_out(fsync), .o_seg_drive_en(seg_en),
    .o_word_valid(wv), .o_word_data(wdata), .o_word_is_data(wd_dc), .o_host_bus_mode(mode));
  host_mcu_model host (.i_clk(clk), .i_bus(bus), .o_cs_n(cs_n), .o_dc(dc),
    .o_rw_wr(rw_wr), .o_e_rd(e_rd), .o_data(hdata));

  // Log each received word
  always @(posedge clk)
    if (wv === 1'b1)
    begin
      n_words <= n_words + 1;
      last_w  <= wdata;
      last_dc <= wd_dc;
    end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The slave ties hready high, so no phase is stretched; wait with a bound all the same
  task automatic wait_ready;
    int t;
    t = 0;
    @(posedge clk);
    while (hready !== 1'b1 && t < 20)
    begin
      @(posedge clk);
      t++;
    end
    if (t == 20)
    begin
      check(32'h0, 32'h1);
      end_sim();
    end
  endtask

  task automatic ahb(input logic wr, input logic [2:0] sz, input logic [11:0] a,
                     input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= {20'h00000, a};
    hwrite <= wr;
    hsize  <= sz;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, HSIZE_WORD, a, 32'h0);
    check(r, e);
    check(hresp, 1'b0);
  endtask

  task automatic set_mode(input logic [3:0] m);
    strap <= m[1:0];
    ahb(1'b1, HSIZE_WORD, REG_CTRL, {29'h0, 1'b1, m[3:2]});
    repeat (6) @(posedge clk);
  endtask

  // Host write, then long enough for the four-edge word latency
  task automatic send(input int k, input logic sel_n, input logic d_c, input logic [17:0] d,
                      input int nb);
    host.write_word(k, sel_n, d_c, d, nb);
    repeat (8) @(posedge clk);
  endtask

  task automatic count_sync(input int n);
    c = 0;
    repeat (n)
    begin
      @(negedge clk);
      c += (fsync === 1'b1);
    end
  endtask

  function automatic int kind_of(input logic [3:0] m);
    return (m[3:1] == 3'h0) ? 2 + m[0] : int'(m[0]);
  endfunction

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(mode, 4'h0);
    check(seg_en, 1'b0);
    rdc(REG_CTRL, 32'h0);
    rdc(REG_FRAME, {16'h0, FRAME_RST});
    rdc(12'h020, 32'h0);
    ahb(1'b1, 3'h0, REG_TXDATA, 32'h1);
    rdc(REG_TXDATA, 32'h0);
    ahb(1'b0, HSIZE_WORD, REG_STATUS, 32'h0);
    check(r[5:0], 6'h30);
    foreach (rows[i])
    begin
      set_mode(rows[i].m);
      check(mode, rows[i].m);
      w0 = n_words;
      send(kind_of(rows[i].m), 1'b0, rows[i].dc, rows[i].d, 8 + rows[i].m[0]);
      check(n_words - w0, 32'h1);
      check(last_w, rows[i].e);
      check(last_dc, rows[i].dc);
      check(seg_en, 1'b1);
      rdc(REG_RXWORD, {1'b1, 12'h0, rows[i].dc, rows[i].e});
    end
    rdc(REG_RXWORD, {13'h0, rows[7].dc, rows[7].e});
    ahb(1'b1, HSIZE_WORD, REG_TXDATA, 32'h0003A5C3);
    for (int j = 0; j < 2; j++)
    begin
      set_mode(j ? 4'h3 : 4'h6);
      host.read_word(j, v);
      check(v, j ? 18'h000C3 : 18'h0A5C3);
    end
    set_mode(4'h2);
    send(0, 1'b0, 1'b0, 18'h00036, 8);
    send(0, 1'b0, 1'b1, 18'h00001, 8);
    check(mode, 4'h6);
    set_mode(4'h4);
    w0 = n_words;
    send(0, 1'b0, 1'b1, 18'h00011, 8);
    check(n_words - w0, 32'h0);
    ahb(1'b0, HSIZE_WORD, REG_STATUS, 32'h0);
    check(r[4:0], 5'h04);
    set_mode(4'h0);
    w0 = n_words;
    send(2, 1'b0, 1'b1, 18'h000FF, 4);
    send(2, 1'b1, 1'b1, 18'h00081, 8);
    send(2, 1'b0, 1'b0, 18'h0005A, 8);
    check(n_words - w0, 32'h1);
    check(last_w, 18'h0005A);
    ahb(1'b1, HSIZE_WORD, REG_FRAME, FRM);
    repeat (40) @(posedge clk);
    count_sync(64);
    check(c, 64 / (FRM * DIV) * SYNC_TICKS * DIV);
    osc_sel <= 1'b0;
    repeat (80) @(posedge clk);
    count_sync(128);
    check(c, 2 * SYNC_TICKS * 8);
    init_n <= 1'b0; // only lowered here
    repeat (8) @(posedge clk);
    init_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(seg_en, 1'b0);
    rdc(REG_CTRL, 32'h0);
    rdc(REG_FRAME, {16'h0, FRAME_RST});
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
